/* File: anr_consts.svh */
`ifndef ANR_CONSTS_SVH
`define ANR_CONSTS_SVH

// Register indices; byte address is four times the index
`define ANR_IDX_EXP        6'h06
`define ANR_IDX_NP_TX      6'h07
`define ANR_IDX_NP_RX      6'h08
`define ANR_IDX_MS         6'h0A
`define ANR_IDX_IRQ_STAT   6'h10
`define ANR_IDX_IRQ_MASK   6'h11

// Expansion register fields
`define ANR_EXP_PD_FAULT   4
`define ANR_EXP_PART_NP    3
`define ANR_EXP_LOCAL_NP   2
`define ANR_EXP_PAGE_RX    1
`define ANR_EXP_PART_AN    0
`define ANR_LOCAL_NP_ABLE  1'h1

// Next page fields and masks
`define ANR_NP_MORE        15
`define ANR_NP_MSG_SEL     13
`define ANR_NP_SECOND_ACK  12
`define ANR_NP_TOGGLE      11
`define ANR_NP_CODE_MSB    10
`define ANR_NP_TX_RESET    16'h0001
`define ANR_NP_TX_WMASK    16'hB7FF
`define ANR_NP_RX_MASK     16'hBFFF
`define ANR_NP_RX_RESET    16'h0000

// Master/slave status fields
`define ANR_MS_FAULT       15
`define ANR_MS_MASTER      14
`define ANR_MS_LOCAL_OK    13
`define ANR_MS_REMOTE_OK   12
`define ANR_MS_GIG_FD      11
`define ANR_MS_GIG_LP_HD   10
`define ANR_IDLE_MAX       8'hFF

// Interrupt status bits
`define ANR_IRQ_PD_FAULT   0
`define ANR_IRQ_PAGE_RX    1
`define ANR_IRQ_MS_FAULT   2
`define ANR_IRQ_IDLE_ERR   3

// Bus answers
`define ANR_RESP_OKAY      2'h0
`define ANR_RESP_SLVERR    2'h2

`endif

/* File: anr_pkg.sv */
package anr_pkg;

  typedef logic [15:0] anr_word_t;
  typedef logic [10:0] anr_code_t;
  typedef logic [7:0]  anr_addr_t;
  typedef logic [31:0] anr_data_t;
  typedef logic [3:0]  anr_strb_t;
  typedef logic [1:0]  anr_resp_t;
  typedef logic [7:0]  anr_count_t;
  typedef logic [3:0]  anr_irq_t;

endpackage : anr_pkg

/* File: anr_sticky_flags.sv */
`timescale 1ns/1ps
`include "anr_consts.svh"

module anr_sticky_flags #(
  parameter int unsigned N = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Set and clear strobes
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  // Flag state
  output logic      [N-1:0] flags
);
  import anr_pkg::*;

  logic [N-1:0] flag_r;

  // One sticky flag per bit; a set in the clearing cycle wins
  for (genvar i = 0; i < N; i++)
  begin : g_flag
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        flag_r[i] <= 1'b0;
      else
        flag_r[i] <= set[i] | (flag_r[i] & ~clr[i]);
    end
  end

  assign flags = flag_r;

endmodule : anr_sticky_flags

/* File: anr_idle_counter.sv */
`timescale 1ns/1ps
`include "anr_consts.svh"

module anr_idle_counter (
  // Clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // Error event and read clear
  input  wire logic      evt,
  input  wire logic      clr,
  // Count
  output anr_pkg::anr_count_t count
);
  import anr_pkg::*;

  anr_count_t cnt_r;
  anr_count_t cnt_nxt;
  wire        at_max = (cnt_r == `ANR_IDLE_MAX);

  // Saturates so a long burst never wraps to a small count; an event
  // in the read cycle restarts the count at one rather than being lost
  assign cnt_nxt = clr ? {7'h00, evt}
                 : (evt && !at_max) ? cnt_r + 8'h01
                 : cnt_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_nxt;
  end

  assign count = cnt_r;

endmodule : anr_idle_counter

/* File: anr_regs.sv */
`timescale 1ns/1ps
`include "anr_consts.svh"

// Function
// [RULE_01] A parallel detection fault sets expansion bit 4, a read clears it.
// [RULE_02] A newly received page sets expansion bit 1, a read clears it.
// [RULE_03] Expansion bit 2 is read-only and reads one, local next page able.
// [RULE_04] Expansion bit 3 reads one when the partner is next page able.
// [RULE_05] Expansion bit 0 shows partner autoneg ability while autoneg is on.
// [RULE_06] Transmit bit 15 is writable: one means more pages follow.
// [RULE_07] Bit 13 selects message code or unformatted code for bits 10:0.
// [RULE_08] Bit 12 says comply or not; writable on transmit, read-only on rx.
// [RULE_09] Toggle bit 11 is read-only, the complement of the last toggle.
// [RULE_10] The transmit register resets to code 0x1 with all else zero.
// [RULE_11] Each received next page is captured read-only, reset zero.
// [RULE_12] Master/slave bit 15 flags a manual config fault, cleared on read.
// [RULE_13] Master/slave bit 14 reads one for master and zero for slave.
// [RULE_14] Bits 13 and 12 report local and remote receiver good.
// [RULE_15] Bits 11 and 10 are read-only gigabit indications, reset zero.
// [RULE_16] Bits 7:0 count idle errors since the last read of the register.
// [RULE_17] The counter saturates; reserved bits read zero and ignore writes.
module anr_regs (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write address and data
  input  wire anr_pkg::anr_addr_t s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire anr_pkg::anr_data_t s_axi_wdata,
  input  wire anr_pkg::anr_strb_t s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // AXI4-Lite write response
  output anr_pkg::anr_resp_t s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read
  input  wire anr_pkg::anr_addr_t s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output anr_pkg::anr_data_t s_axi_rdata,
  output anr_pkg::anr_resp_t s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Negotiation engine status
  input  wire logic          autoneg_enable,
  input  wire logic          partner_autoneg_able,
  input  wire logic          partner_np_able,
  input  wire logic          pd_fault_evt,
  input  wire logic          page_rx_evt,
  input  wire anr_pkg::anr_word_t rx_page_word,
  input  wire logic          tx_page_done,
  // Master/slave and receiver status
  input  wire logic          ms_fault_evt,
  input  wire logic          ms_resolved_master,
  input  wire logic          local_rx_ok,
  input  wire logic          remote_rx_ok,
  input  wire logic          gig_full_duplex,
  input  wire logic          gig_partner_half,
  input  wire logic          idle_err_evt,
  // Pages toward the engine
  output anr_pkg::anr_word_t tx_page_word,
  output anr_pkg::anr_code_t tx_message_code,
  output anr_pkg::anr_code_t tx_unformatted_code,
  output anr_pkg::anr_code_t rx_message_code,
  output anr_pkg::anr_code_t rx_unformatted_code,
  // Interrupt
  output logic               irq
);
  import anr_pkg::*;

  // Bus handshake state
  logic       awready_r;
  logic       wready_r;
  logic       bvalid_r;
  anr_resp_t  bresp_r;
  logic       arready_r;
  logic       rvalid_r;
  anr_data_t  rdata_r;
  anr_resp_t  rresp_r;
  logic       aw_hold_r;
  logic       w_hold_r;
  anr_addr_t  awaddr_r;
  anr_data_t  wdata_r;
  anr_strb_t  wstrb_r;

  // Register state
  anr_word_t  np_tx_r;
  anr_word_t  np_rx_r;
  logic       toggle_r;
  logic       part_an_r;
  logic       part_np_r;
  logic [4:0] ms_live_r;
  anr_irq_t   irq_mask_r;
  logic       irq_r;

  // Registered outputs toward the engine
  anr_word_t  tx_page_word_r;
  anr_code_t  tx_msg_r;
  anr_code_t  tx_unf_r;
  anr_code_t  rx_msg_r;
  anr_code_t  rx_unf_r;

  // Leaf results
  logic [2:0] rc_flags;
  anr_irq_t   irq_stat;
  anr_count_t idle_cnt;

  // Write channel acceptance; address and data may come in either order
  wire aw_take  = s_axi_awvalid & awready_r;
  wire w_take   = s_axi_wvalid & wready_r;
  wire aw_have  = aw_hold_r | aw_take;
  wire w_have   = w_hold_r | w_take;
  wire do_write = aw_have & w_have & ~bvalid_r;
  wire bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready);
  wire aw_hold_nxt = aw_have & ~do_write;
  wire w_hold_nxt  = w_have & ~do_write;

  // Write decode uses the held copy when that channel came first
  wire anr_addr_t wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
  wire anr_data_t wr_data = w_hold_r ? wdata_r : s_axi_wdata;
  wire anr_strb_t wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb;
  wire [5:0] wr_idx   = wr_addr[7:2];
  wire wr_tx   = do_write & (wr_idx == `ANR_IDX_NP_TX);
  wire wr_stat = do_write & (wr_idx == `ANR_IDX_IRQ_STAT) & wr_strb[0];
  wire wr_mask = do_write & (wr_idx == `ANR_IDX_IRQ_MASK) & wr_strb[0];
  wire wr_hit  = (wr_idx == `ANR_IDX_EXP) | (wr_idx == `ANR_IDX_NP_TX)
               | (wr_idx == `ANR_IDX_NP_RX) | (wr_idx == `ANR_IDX_MS)
               | (wr_idx == `ANR_IDX_IRQ_STAT)
               | (wr_idx == `ANR_IDX_IRQ_MASK);

  // Read acceptance; one read outstanding at a time
  wire ar_take    = s_axi_arvalid & arready_r;
  wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire rd_exp = ar_take & (rd_idx == `ANR_IDX_EXP);
  wire rd_ms  = ar_take & (rd_idx == `ANR_IDX_MS);

  // Byte lanes limit the transmit update; reserved and toggle bits stay
  wire anr_word_t lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire anr_word_t tx_wmask  = lane_mask & `ANR_NP_TX_WMASK; // see [RULE_06]
  wire anr_word_t np_tx_nxt = wr_tx
                            ? ((np_tx_r & ~tx_wmask)
                               | (wr_data[15:0] & tx_wmask)) // see [RULE_08]
                            : np_tx_r;

  // Register views as software sees them
  wire anr_word_t exp_word = {11'h000,
                              rc_flags[1],          // see [RULE_01]
                              part_np_r,            // see [RULE_04]
                              `ANR_LOCAL_NP_ABLE,   // see [RULE_03]
                              rc_flags[0],          // see [RULE_02]
                              part_an_r};           // see [RULE_05]
  wire anr_word_t tx_word  = {np_tx_r[15], 1'b0, np_tx_r[13:12],
                              toggle_r, np_tx_r[10:0]}; // see [RULE_09]
  wire anr_word_t ms_word  = {rc_flags[2],          // see [RULE_12]
                              ms_live_r, 2'h0,      // see [RULE_17]
                              idle_cnt};            // see [RULE_16]

  // Read selection; an unmapped address answers SLVERR with zero data
  wire rd_hit = (rd_idx == `ANR_IDX_EXP) | (rd_idx == `ANR_IDX_NP_TX)
              | (rd_idx == `ANR_IDX_NP_RX) | (rd_idx == `ANR_IDX_MS)
              | (rd_idx == `ANR_IDX_IRQ_STAT)
              | (rd_idx == `ANR_IDX_IRQ_MASK);
  wire anr_word_t rd_word =
      (rd_idx == `ANR_IDX_EXP)      ? exp_word
    : (rd_idx == `ANR_IDX_NP_TX)    ? tx_word
    : (rd_idx == `ANR_IDX_NP_RX)    ? np_rx_r
    : (rd_idx == `ANR_IDX_MS)       ? ms_word
    : (rd_idx == `ANR_IDX_IRQ_STAT) ? {12'h000, irq_stat}
    : (rd_idx == `ANR_IDX_IRQ_MASK) ? {12'h000, irq_mask_r}
    : 16'h0000;

  // Events for the interrupt status register
  wire anr_irq_t irq_set = {idle_err_evt, ms_fault_evt,
                            page_rx_evt, pd_fault_evt};
  wire anr_irq_t irq_clr = wr_stat ? wr_data[3:0] : 4'h0;

  // Message/unformatted split; the other view reads zero
  wire anr_code_t tx_code = np_tx_r[`ANR_NP_CODE_MSB:0];
  wire anr_code_t rx_code = np_rx_r[`ANR_NP_CODE_MSB:0];
  wire tx_is_msg = np_tx_r[`ANR_NP_MSG_SEL];
  wire rx_is_msg = np_rx_r[`ANR_NP_MSG_SEL];

  // Clear-on-read flags: page received, parallel fault, config fault
  anr_sticky_flags #(
    .N       (3)
  ) u_rc_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     ({ms_fault_evt, pd_fault_evt, page_rx_evt}),
    .clr     ({rd_ms, rd_exp, rd_exp}), // see [RULE_01] see [RULE_02]
    .flags   (rc_flags)
  );

  // Write-one-to-clear interrupt status
  anr_sticky_flags #(
    .N       (4)
  ) u_irq_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (irq_set),
    .clr     (irq_clr),
    .flags   (irq_stat)
  );

  // Idle error count, restarted by each master/slave read
  anr_idle_counter u_idle_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .evt     (idle_err_evt),
    .clr     (rd_ms),              // see [RULE_16] see [RULE_17]
    .count   (idle_cnt)
  );

  // Write channel flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `ANR_RESP_OKAY;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
    end
    else
    begin
      awready_r <= ~bvalid_nxt & ~aw_hold_nxt;
      wready_r  <= ~bvalid_nxt & ~w_hold_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= do_write ? (wr_hit ? `ANR_RESP_OKAY : `ANR_RESP_SLVERR)
                            : bresp_r;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
    end
  end

  // Payload holding; no reset needed, guarded by the hold bits
  always_ff @(posedge aclk)
  begin
    if (aw_take)
      awaddr_r <= s_axi_awaddr;
    if (w_take)
    begin
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
  end

  // Read channel flops; data is a snapshot taken with the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= `ANR_RESP_OKAY;
    end
    else
    begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take)
      begin
        rdata_r <= {16'h0000, rd_word};
        rresp_r <= rd_hit ? `ANR_RESP_OKAY : `ANR_RESP_SLVERR;
      end
    end
  end

  // Page registers and toggle tracking
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      np_tx_r  <= `ANR_NP_TX_RESET;                 // see [RULE_10]
      np_rx_r  <= `ANR_NP_RX_RESET;
      toggle_r <= 1'b0;
    end
    else
    begin
      np_tx_r  <= np_tx_nxt;
      if (page_rx_evt)
        np_rx_r <= rx_page_word & `ANR_NP_RX_MASK;  // see [RULE_11]
      if (tx_page_done)
        toggle_r <= ~toggle_r;                      // see [RULE_09]
    end
  end

  // Live status snapshot; zero while reset so defaults read zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      part_an_r <= 1'b0;
      part_np_r <= 1'b0;
      ms_live_r <= 5'h00;
    end
    else
    begin
      // Partner autoneg ability has no meaning with negotiation off
      part_an_r <= partner_autoneg_able & autoneg_enable; // see [RULE_05]
      part_np_r <= partner_np_able;                       // see [RULE_04]
      ms_live_r <= {ms_resolved_master,                   // see [RULE_13]
                    local_rx_ok, remote_rx_ok,            // see [RULE_14]
                    gig_full_duplex, gig_partner_half};   // see [RULE_15]
    end
  end

  // Interrupt mask and output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_mask_r <= 4'h0;
      irq_r      <= 1'b0;
    end
    else
    begin
      if (wr_mask)
        irq_mask_r <= wr_data[3:0];
      irq_r <= |(irq_stat & irq_mask_r);
    end
  end

  // Page words toward the engine, split by the message select bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_page_word_r <= 16'h0000;
      tx_msg_r       <= 11'h000;
      tx_unf_r       <= 11'h000;
      rx_msg_r       <= 11'h000;
      rx_unf_r       <= 11'h000;
    end
    else
    begin
      tx_page_word_r <= tx_word;
      tx_msg_r <= tx_is_msg ? tx_code : 11'h000;  // see [RULE_07]
      tx_unf_r <= tx_is_msg ? 11'h000 : tx_code;
      rx_msg_r <= rx_is_msg ? rx_code : 11'h000;  // see [RULE_07]
      rx_unf_r <= rx_is_msg ? 11'h000 : rx_code;
    end
  end

  assign s_axi_awready       = awready_r;
  assign s_axi_wready        = wready_r;
  assign s_axi_bvalid        = bvalid_r;
  assign s_axi_bresp         = bresp_r;
  assign s_axi_arready       = arready_r;
  assign s_axi_rvalid        = rvalid_r;
  assign s_axi_rdata         = rdata_r;
  assign s_axi_rresp         = rresp_r;
  assign tx_page_word        = tx_page_word_r;
  assign tx_message_code     = tx_msg_r;
  assign tx_unformatted_code = tx_unf_r;
  assign rx_message_code     = rx_msg_r;
  assign rx_unformatted_code = rx_unf_r;
  assign irq                 = irq_r;

  // Checks
  sequence s_exp_read;
    ar_take && (rd_idx == `ANR_IDX_EXP) ##1 rvalid_r;
  endsequence

  property p_pd_set;
    @(posedge aclk) disable iff (!aresetn)
    pd_fault_evt |=> rc_flags[1];
  endproperty
  a_pd_set: assert property (p_pd_set) // see [RULE_01]
    else $error("parallel fault flag not set");

  property p_page_clear;
    @(posedge aclk) disable iff (!aresetn)
    rd_exp && !page_rx_evt |=> !rc_flags[0];
  endproperty
  a_page_clear: assert property (p_page_clear) // see [RULE_02]
    else $error("page flag not cleared by read");

  property p_local_np;
    @(posedge aclk) disable iff (!aresetn)
    s_exp_read |-> s_axi_rdata[`ANR_EXP_LOCAL_NP];
  endproperty
  a_local_np: assert property (p_local_np) // see [RULE_03]
    else $error("local next page ability not one");

  property p_an_gate;
    @(posedge aclk) disable iff (!aresetn)
    !autoneg_enable |=> !part_an_r;
  endproperty
  a_an_gate: assert property (p_an_gate) // see [RULE_05]
    else $error("partner ability shown with autoneg off");

  property p_tx_split;
    @(posedge aclk) disable iff (!aresetn)
    tx_is_msg |=> (tx_msg_r == $past(tx_code)) && (tx_unf_r == 11'h000);
  endproperty
  a_tx_split: assert property (p_tx_split) // see [RULE_07]
    else $error("message code view wrong");

  property p_toggle;
    @(posedge aclk) disable iff (!aresetn)
    tx_page_done |=> toggle_r != $past(toggle_r);
  endproperty
  a_toggle: assert property (p_toggle) // see [RULE_09]
    else $error("toggle did not flip");

  property p_rx_capture;
    @(posedge aclk) disable iff (!aresetn)
    page_rx_evt |=> np_rx_r == ($past(rx_page_word) & `ANR_NP_RX_MASK);
  endproperty
  a_rx_capture: assert property (p_rx_capture) // see [RULE_11]
    else $error("received page not captured");

  property p_ms_clear;
    @(posedge aclk) disable iff (!aresetn)
    rd_ms && !ms_fault_evt |=> !rc_flags[2];
  endproperty
  a_ms_clear: assert property (p_ms_clear) // see [RULE_12]
    else $error("config fault not cleared by read");

  property p_cnt_clear;
    @(posedge aclk) disable iff (!aresetn)
    rd_ms |=> idle_cnt == {7'h00, $past(idle_err_evt)};
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) // see [RULE_16]
    else $error("idle count not restarted");

  property p_cnt_sat;
    @(posedge aclk) disable iff (!aresetn)
    (idle_cnt == `ANR_IDLE_MAX) && !rd_ms |=> idle_cnt == `ANR_IDLE_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) // see [RULE_17]
    else $error("idle count wrapped");

endmodule : anr_regs

/* File: anr_link_partner.sv */
`timescale 1ns/1ps

// Plays the negotiation engine and the remote partner behind it
module anr_link_partner (
  // Clock
  input  wire logic          aclk,
  // Event strobes
  output logic               pd_fault_evt,
  output logic               ms_fault_evt,
  output logic               idle_err_evt,
  output logic               tx_page_done,
  // Received page
  output logic               page_rx_evt,
  output anr_pkg::anr_word_t rx_page_word
);
  import anr_pkg::*;

  logic [3:0] ev_r;

  // Strobe lines: 0 fault, 1 master/slave fault, 2 idle error, 3 page sent
  assign pd_fault_evt = ev_r[0];
  assign ms_fault_evt = ev_r[1];
  assign idle_err_evt = ev_r[2];
  assign tx_page_done = ev_r[3];

  // Quiet start; the page word holds junk until a page is offered
  initial
  begin
    ev_r         = 4'h0;
    page_rx_evt  = 1'b0;
    rx_page_word = 16'hA5A5;
  end

  // One-cycle strobes with a quiet cycle between, so each one counts
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      ev_r[k] <= 1'b1;
      @(posedge aclk);
      ev_r[k] <= 1'b0;
    end
  endtask : pulse

  // Word valid only with its strobe; scrambled after so stale use shows
  task automatic send_page(input anr_word_t w);
    @(posedge aclk);
    rx_page_word <= w;
    page_rx_evt  <= 1'b1;
    @(posedge aclk);
    rx_page_word <= ~w;
    page_rx_evt  <= 1'b0;
  endtask : send_page

endmodule : anr_link_partner

/* File: anr_regs_test.sv */
`timescale 1ns/1ps
`include "anr_consts.svh"

module anr_regs_test;
  import anr_pkg::*;

  // Clock, reset and register bus
  logic      aclk, aresetn;
  anr_addr_t s_axi_awaddr, s_axi_araddr;
  logic      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  anr_data_t s_axi_wdata, s_axi_rdata, rd_data;
  anr_strb_t s_axi_wstrb;
  anr_resp_t s_axi_bresp, s_axi_rresp, rs;
  logic      s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic      s_axi_rvalid, s_axi_rready;
  // Engine levels, events and page views
  logic      autoneg_enable, partner_autoneg_able, partner_np_able;
  logic      ms_resolved_master, local_rx_ok, remote_rx_ok;
  logic      gig_full_duplex, gig_partner_half, irq;
  logic      pd_fault_evt, page_rx_evt, tx_page_done, ms_fault_evt;
  logic      idle_err_evt;
  anr_word_t rx_page_word, tx_page_word;
  anr_code_t tx_message_code, tx_unformatted_code;
  anr_code_t rx_message_code, rx_unformatted_code;
  int        fail_count, tests_run;

  anr_regs anr_regs_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .autoneg_enable, .partner_autoneg_able,
    .partner_np_able, .pd_fault_evt, .page_rx_evt, .rx_page_word,
    .tx_page_done, .ms_fault_evt, .ms_resolved_master, .local_rx_ok,
    .remote_rx_ok, .gig_full_duplex, .gig_partner_half, .idle_err_evt,
    .tx_page_word, .tx_message_code, .tx_unformatted_code,
    .rx_message_code, .rx_unformatted_code, .irq);

  anr_link_partner anr_link_partner_inst (
    .aclk, .pd_fault_evt, .ms_fault_evt, .idle_err_evt, .tx_page_done,
    .page_rx_evt, .rx_page_word);

  // 125 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Compare and count
  task automatic check(input anr_data_t seen, input anr_data_t exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Write: both channels offered together, each dropped when taken
  task automatic wr(input anr_addr_t a, input anr_word_t d,
                    input anr_strb_t s = 4'hF);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50)
      fail_count++;
  endtask : wr

  // Read: address held until taken, rready until the answer
  task automatic rd(input anr_addr_t a);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    rd_data = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50)
      fail_count++;
  endtask : rd

  task automatic rchk(input anr_addr_t a, input anr_data_t e);
    rd(a);
    check(rd_data, e);
  endtask : rchk

  // Verdict, reached from the sequence or the watchdog
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Watchdog: the sequence needs about 750 cycles, this allows 25000
  initial
  begin
    #200000;
    fail_count++;
    final_report();
  end

  // Main sequence
  initial
  begin
    fail_count = 0;
    tests_run  = 0;
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb,
     s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid,
     s_axi_rready, autoneg_enable, partner_autoneg_able, partner_np_able,
     ms_resolved_master, local_rx_ok, remote_rx_ok, gig_full_duplex,
     gig_partner_half} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h18, 32'h0004);
    rchk(8'h1C, 32'h0001);
    rchk(8'h20, 32'h0000);
    rchk(8'h28, 32'h0000);
    {autoneg_enable, partner_autoneg_able, partner_np_able} <= 3'b111;
    rchk(8'h18, 32'h000D);
    autoneg_enable <= 1'b0;
    wr(8'h18, 16'hFFFF);
    rchk(8'h18, 32'h000C);
    // Fault and page flags are read once, then gone
    anr_link_partner_inst.pulse(0, 1);
    anr_link_partner_inst.send_page(16'hFFFF);
    rchk(8'h18, 32'h001E);
    rchk(8'h18, 32'h000C);
    rchk(8'h20, 32'hBFFF);
    check(anr_data_t'(rx_message_code), 32'h7FF);
    check(anr_data_t'(rx_unformatted_code), 32'h0);
    anr_link_partner_inst.send_page(16'h0555);
    wr(8'h20, 16'hFFFF);
    check(anr_data_t'(rs), `ANR_RESP_OKAY);
    rchk(8'h20, 32'h0555);
    check(anr_data_t'(rx_unformatted_code), 32'h555);
    check(anr_data_t'(rx_message_code), 32'h0);
    // Transmit page: writable bits, toggle follows exchanged pages
    wr(8'h1C, 16'hFFFF);
    rchk(8'h1C, 32'hB7FF);
    check(anr_data_t'(tx_message_code), 32'h7FF);
    anr_link_partner_inst.pulse(3, 1);
    rchk(8'h1C, 32'hBFFF);
    wr(8'h1C, 16'h1234);
    rchk(8'h1C, 32'h1A34);
    check(anr_data_t'(tx_unformatted_code), 32'h234);
    check(anr_data_t'(tx_page_word), 32'h1A34);
    anr_link_partner_inst.pulse(3, 1);
    wr(8'h1C, 16'h0000);
    rchk(8'h1C, 32'h0000);
    // Only the strobed low lane may change
    wr(8'h1C, 16'hFFFF, 4'h1);
    rchk(8'h1C, 32'h00FF);
    // Master/slave status, clear on read and saturating count
    {ms_resolved_master, local_rx_ok, remote_rx_ok, gig_full_duplex,
     gig_partner_half} <= 5'h1F;
    anr_link_partner_inst.pulse(1, 1);
    anr_link_partner_inst.pulse(2, 3);
    rchk(8'h28, 32'hFC03);
    rchk(8'h28, 32'h7C00);
    ms_resolved_master <= 1'b0;
    anr_link_partner_inst.pulse(2, 300);
    rchk(8'h28, 32'h3CFF);
    rchk(8'h28, 32'h3C00);
    // Interrupt: raise through mask, clear by writing one
    rchk(8'h40, 32'h000F);
    check({31'h0, irq}, 32'h0);
    wr(8'h44, 16'h0004);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    wr(8'h40, 16'h0004);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    rchk(8'h40, 32'h000B);
    // Unmapped places answer with an error
    rd(8'h3C);
    check(rd_data, 32'h0);
    check(anr_data_t'(rs), `ANR_RESP_SLVERR);
    wr(8'h30, 16'hFFFF);
    check(anr_data_t'(rs), `ANR_RESP_SLVERR);
    // Reset in mid-run brings the transmit page and status back
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h1C, 32'h0001);
    rchk(8'h40, 32'h0000);
    final_report();
  end

endmodule : anr_regs_test
